// file: cal_event_gen.sv
`timescale 1ns/1ps

// Counts the programmed latency after a calibration command and then
// issues one calibration event, unless the event is masked.
module cal_event_gen #(
    parameter int LAT_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control
    input wire logic cal_cmd,
    input wire logic [LAT_W-1:0] latency,
    input wire logic calibration_event_mask,
    // Event out
    output logic cal_event,
    output logic cal_busy
);

    // One-hot sequencer states
    typedef enum logic [1:0] {
        CAL_IDLE = 2'b01,
        CAL_COUNT = 2'b10
    } cal_state_t;

    cal_state_t state_r; // Current state
    logic [LAT_W-1:0] cnt_r; // Cycles left before the event
    logic event_r; // Registered event pulse

    // Sequencer; a command that arrives while counting is dropped
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_r <= CAL_IDLE;
            cnt_r <= '0;
        end else begin
            case (state_r)
                CAL_IDLE: begin
                    if (cal_cmd) begin
                        state_r <= CAL_COUNT;
                        cnt_r <= latency; // RL13
                    end
                end
                CAL_COUNT: begin
                    if (cnt_r <= LAT_W'(1)) begin
                        state_r <= CAL_IDLE;
                    end
                    cnt_r <= cnt_r - LAT_W'(1);
                end
                default: begin
                    state_r <= CAL_IDLE;
                end
            endcase
        end
    end

    // Event pulse, gated by the mask bit sampled at expiry
    always_ff @(posedge clk) begin
        if (!rstn) begin
            event_r <= 1'b0;
        end else begin
            event_r <= (state_r == CAL_COUNT) && (cnt_r <= LAT_W'(1))
                && !calibration_event_mask; // RL7
        end
    end

    assign cal_event = event_r;
    assign cal_busy = (state_r == CAL_COUNT);

endmodule : cal_event_gen

// file: cfg_regs_pkg.sv
package cfg_regs_pkg;

    // Register offsets on the internal configuration access port
    localparam logic [7:0] MAIN_CONFIGURATION_ADDR = 8'h00;
    localparam logic [7:0] EXTENDED_CONFIGURATION_ADDR = 8'h01;
    localparam logic [7:0] LATENCY_ADDR = 8'h06;
    localparam logic [7:0] FIFO_SELECT_ADDR = 8'h0D;
    localparam logic [7:0] FIFO_DATA_HI_ADDR = 8'h0E;
    localparam logic [7:0] FIFO_DATA_LO_ADDR = 8'h0F;
    localparam logic [7:0] FIRST_STATUS_ADDR = 8'h10;

    // Main configuration bit positions
    localparam int OPERATING_MODE_BIT = 7;
    localparam int TRIGGER_INHIBIT_BIT = 6;
    localparam int TRANSMIT_DISABLE_BIT = 5;
    localparam int LINK_TEST_BIT = 4;
    localparam int CHANNEL_ENABLE_MSB = 3;

    // Extended configuration bit positions
    localparam int CAL_EVENT_MASK_BIT = 1;
    localparam int DLL_DISABLE_BIT = 0;

    // First status bit positions
    localparam int OUT_OF_SYNC_BIT = 7;
    localparam int LINK_READY_BIT = 6;

    // Values after reset
    localparam logic [7:0] MAIN_CONFIGURATION_RST = 8'h00;
    localparam logic [1:0] EXTENDED_CONFIGURATION_RST = 2'h0;
    localparam logic [7:0] LATENCY_RST = 8'h80;
    localparam logic [5:0] FIFO_SELECT_RST = 6'h00;

    // FIFO data word layout
    localparam int FIFO_WORD_W = 12;
    localparam int FIFO_HI_W = 4;

endpackage : cfg_regs_pkg

// file: fifo_partner.sv
`timescale 1ns/1ps

// Stands in for the internal FIFO that link test writes and reads reach.
module fifo_partner (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Test access from the register group
    input wire logic [5:0] fifo_select,
    input wire logic fifo_wr,
    input wire logic [11:0] fifo_wdata,
    input wire logic fifo_rd,
    // Head word back to the register group
    output logic [11:0] fifo_rdata
);
    logic [11:0] mem_r [0:7]; // Word storage
    logic [2:0] wp_r; // Write pointer
    logic [2:0] rp_r; // Read pointer
    logic [3:0] cnt_r; // Words held
    logic [11:0] idle_r; // Toggles so an empty FIFO never looks stable
    logic push; // Word really stored this cycle
    logic pop; // Word really removed this cycle

    // Count only what is stored or removed, so the fill level stays true
    assign push = fifo_wr && fifo_select != 6'h00 && cnt_r != 4'h8;
    assign pop = fifo_rd && cnt_r != 4'h0;

    // Push on a write strobe only when a FIFO is picked; pop on a read strobe whatever the selection
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wp_r <= 3'h0;
            rp_r <= 3'h0;
            cnt_r <= 4'h0;
            idle_r <= 12'hA5A;
        end else begin
            idle_r <= ~idle_r;
            if (push) begin
                mem_r[wp_r] <= fifo_wdata;
                wp_r <= wp_r + 3'h1;
            end
            if (pop) begin
                rp_r <= rp_r + 3'h1;
            end
            cnt_r <= cnt_r + {3'h0, push} - {3'h0, pop};
        end
    end

    // Empty FIFO shows a moving pattern rather than the last word
    assign fifo_rdata = (cnt_r != 4'h0) ? mem_r[rp_r] : idle_r;
endmodule : fifo_partner

// file: front_end_config_status_regs.sv
`timescale 1ns/1ps

//
// Contract
// (RL1) Bit 7 selects normal or test operation
// (RL2) Bit 6 selects inhibiting or passive trigger
// (RL3) Bit 5 high blocks link transmission
// (RL4) Bit 4 selects link test operation
// (RL5) Reset clears the four mode bits
// (RL6) Bits 3..0 enable input channels D..A
// (RL7) Extended bit 1 suppresses calibration event
// (RL8) Extended bit 0 turns the loop off
// (RL9) Out-of-sync flag sticks until resync/reset
// (RL10) Status bit 6 shows link ready live
// (RL11) Unassigned bits read zero, ignore writes
// (RL12) Resync command clears the whole status; code clears only the out-of-sync flag, not on a loss in the same cycle
// (RL13) Calibration latency programmable, default 128
// (RL14) FIFO data access only in link test
module front_end_config_status_regs #(
    parameter int LAT_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register access from the serial configuration port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Events from the trigger decoder and link
    input wire logic resync_cmd,
    input wire logic cal_cmd,
    input wire logic sync_lost,
    input wire logic optical_link_ready,
    // Configuration outputs
    output logic operating_mode_select,
    output logic trigger_inhibit_select,
    output logic link_transmit_disable,
    output logic link_test_select,
    output logic input_channel_d_enable,
    output logic input_channel_c_enable,
    output logic input_channel_b_enable,
    output logic input_channel_a_enable,
    output logic dll_disable,
    output logic out_of_sync_flag,
    // Calibration event
    output logic cal_event,
    // Internal FIFO test access
    output logic [5:0] fifo_select,
    output logic fifo_wr,
    output logic [11:0] fifo_wdata,
    output logic fifo_rd,
    input wire logic [11:0] fifo_rdata
);

    logic [7:0] main_cfg_r; // Main configuration
    logic [1:0] ext_cfg_r; // Only the two live extended bits
    logic [LAT_W-1:0] latency_r; // Calibration latency in cycles
    logic [5:0] fifo_sel_r; // Targeted internal FIFO
    logic [3:0] fifo_hi_r; // Upper nibble staged for a FIFO write
    logic [11:0] fifo_rd_hold_r; // Word captured by the last FIFO read
    logic oos_r; // Sticky out-of-sync flag
    logic [7:0] rdata_r; // Registered read data
    logic fifo_wr_r; // FIFO write strobe
    logic fifo_rd_r; // FIFO read strobe
    logic [11:0] fifo_wdata_r; // FIFO write word
    logic cal_busy; // Latency count in progress
    logic link_test; // Gate for FIFO data accesses

    // Address match helper shared by write and read decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    assign link_test = main_cfg_r[cfg_regs_pkg::LINK_TEST_BIT];

    // Main configuration; reset clears every bit including the mode bits
    always_ff @(posedge clk) begin
        if (!rstn) begin
            main_cfg_r <= cfg_regs_pkg::MAIN_CONFIGURATION_RST; // RL5
        end else if (reg_wr &&
                     hit(reg_addr, cfg_regs_pkg::MAIN_CONFIGURATION_ADDR)) begin
            main_cfg_r <= reg_wdata; // RL1 RL2 RL3 RL4 RL6
        end
    end

    // Extended configuration; bits 7..2 are not stored at all
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ext_cfg_r <= cfg_regs_pkg::EXTENDED_CONFIGURATION_RST;
        end else if (reg_wr && hit(reg_addr,
                     cfg_regs_pkg::EXTENDED_CONFIGURATION_ADDR)) begin
            ext_cfg_r <= reg_wdata[1:0]; // RL7 RL8 RL11
        end
    end

    // Latency and FIFO selection registers
    always_ff @(posedge clk) begin
        if (!rstn) begin
            latency_r <= LAT_W'(cfg_regs_pkg::LATENCY_RST); // RL13
            fifo_sel_r <= cfg_regs_pkg::FIFO_SELECT_RST;
        end else if (reg_wr) begin
            if (hit(reg_addr, cfg_regs_pkg::LATENCY_ADDR)) begin
                latency_r <= LAT_W'(reg_wdata); // RL13
            end
            if (hit(reg_addr, cfg_regs_pkg::FIFO_SELECT_ADDR)) begin
                fifo_sel_r <= reg_wdata[5:0];
            end
        end
    end

    // FIFO write path: the high byte stages, the low byte commits.
    // Outside link test both writes are dropped so the stage stays stale.
    always_ff @(posedge clk) begin
        if (!rstn) begin
            fifo_hi_r <= '0;
            fifo_wr_r <= 1'b0;
            fifo_wdata_r <= '0;
        end else begin
            fifo_wr_r <= 1'b0;
            if (reg_wr && link_test) begin // RL14
                if (hit(reg_addr, cfg_regs_pkg::FIFO_DATA_HI_ADDR)) begin
                    fifo_hi_r <= reg_wdata[3:0];
                end
                if (hit(reg_addr, cfg_regs_pkg::FIFO_DATA_LO_ADDR)) begin
                    fifo_wr_r <= 1'b1;
                    fifo_wdata_r <= {fifo_hi_r, reg_wdata};
                end
            end
        end
    end

    // FIFO read path: reading the low byte pops one word
    always_ff @(posedge clk) begin
        if (!rstn) begin
            fifo_rd_r <= 1'b0;
            fifo_rd_hold_r <= '0;
        end else begin
            fifo_rd_r <= 1'b0;
            if (reg_rd && link_test &&
                hit(reg_addr, cfg_regs_pkg::FIFO_DATA_LO_ADDR)) begin // RL14
                fifo_rd_r <= 1'b1;
                fifo_rd_hold_r <= fifo_rdata;
            end
        end
    end

    // Sticky out-of-sync; a loss in the resync cycle is kept, not lost
    always_ff @(posedge clk) begin
        if (!rstn) begin
            oos_r <= 1'b0;
        end else if (sync_lost) begin
            oos_r <= 1'b1; // RL9
        end else if (resync_cmd) begin
            oos_r <= 1'b0; // RL12
        end
    end

    // Read data, one cycle after the strobe; unmapped offsets read zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata_r <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                cfg_regs_pkg::MAIN_CONFIGURATION_ADDR: begin
                    rdata_r <= main_cfg_r;
                end
                cfg_regs_pkg::EXTENDED_CONFIGURATION_ADDR: begin
                    rdata_r <= {6'h00, ext_cfg_r}; // RL11
                end
                cfg_regs_pkg::LATENCY_ADDR: begin
                    rdata_r <= 8'(latency_r);
                end
                cfg_regs_pkg::FIFO_SELECT_ADDR: begin
                    rdata_r <= {2'h0, fifo_sel_r};
                end
                cfg_regs_pkg::FIFO_DATA_HI_ADDR: begin
                    // Upper bits of the word popped by the last low read
                    rdata_r <= link_test ? {4'h0, fifo_rd_hold_r[11:8]}
                                         : 8'h00; // RL14
                end
                cfg_regs_pkg::FIFO_DATA_LO_ADDR: begin
                    rdata_r <= link_test ? fifo_rdata[7:0] : 8'h00; // RL14
                end
                cfg_regs_pkg::FIRST_STATUS_ADDR: begin
                    // Link ready is sampled raw; no latching by design
                    rdata_r <= {oos_r, optical_link_ready, 6'h00}; // RL10
                end
                default: begin
                    rdata_r <= 8'h00;
                end
            endcase
        end
    end

    // Calibration event sequencer
    cal_event_gen #(
        .LAT_W(LAT_W)
    ) u_cal_event_gen (
        .clk(clk),
        .rstn(rstn),
        .cal_cmd(cal_cmd),
        .latency(latency_r),
        .calibration_event_mask(ext_cfg_r[cfg_regs_pkg::CAL_EVENT_MASK_BIT]),
        .cal_event(cal_event),
        .cal_busy(cal_busy)
    );

    // Configuration fan-out
    assign operating_mode_select =
        main_cfg_r[cfg_regs_pkg::OPERATING_MODE_BIT]; // RL1
    assign trigger_inhibit_select =
        main_cfg_r[cfg_regs_pkg::TRIGGER_INHIBIT_BIT]; // RL2
    assign link_transmit_disable =
        main_cfg_r[cfg_regs_pkg::TRANSMIT_DISABLE_BIT]; // RL3
    assign link_test_select = link_test; // RL4
    assign input_channel_d_enable = main_cfg_r[3]; // RL6
    assign input_channel_c_enable = main_cfg_r[2]; // RL6
    assign input_channel_b_enable = main_cfg_r[1]; // RL6
    assign input_channel_a_enable = main_cfg_r[0]; // RL6
    assign dll_disable = ext_cfg_r[cfg_regs_pkg::DLL_DISABLE_BIT]; // RL8
    assign out_of_sync_flag = oos_r;
    assign reg_rdata = rdata_r;
    assign fifo_select = fifo_sel_r;
    assign fifo_wr = fifo_wr_r;
    assign fifo_wdata = fifo_wdata_r;
    assign fifo_rd = fifo_rd_r;

    // Checks

    // Written mode bits appear on the outputs one cycle later
    a_mode_bits_write: assert property (@(posedge clk) disable iff (!rstn)
        reg_wr && reg_addr == cfg_regs_pkg::MAIN_CONFIGURATION_ADDR
        |=> {operating_mode_select, trigger_inhibit_select,
             link_transmit_disable, link_test_select}
            == $past(reg_wdata[7:4])) // RL1
        else $error("mode bits did not follow the write");

    // Channel enables follow the low nibble
    a_channel_enables: assert property (@(posedge clk) disable iff (!rstn)
        reg_wr && reg_addr == cfg_regs_pkg::MAIN_CONFIGURATION_ADDR
        |=> {input_channel_d_enable, input_channel_c_enable,
             input_channel_b_enable, input_channel_a_enable}
            == $past(reg_wdata[3:0])) // RL6
        else $error("channel enables did not follow the write");

    // Reset leaves all mode bits low
    a_reset_clears_mode: assert property (@(posedge clk)
        !rstn |=> !operating_mode_select && !trigger_inhibit_select
            && !link_transmit_disable && !link_test_select) // RL5
        else $error("mode bits not cleared by reset");

    // Loop disable follows extended bit 0
    a_dll_disable_write: assert property (@(posedge clk) disable iff (!rstn)
        reg_wr && reg_addr == cfg_regs_pkg::EXTENDED_CONFIGURATION_ADDR
        |=> dll_disable == $past(reg_wdata[0])) // RL8
        else $error("loop disable did not follow the write");

    // The flag holds while no resync arrives
    a_oos_sticky: assert property (@(posedge clk) disable iff (!rstn)
        out_of_sync_flag && !resync_cmd |=> out_of_sync_flag) // RL9
        else $error("out-of-sync flag dropped without resync");

    // Resync without a new loss clears the flag
    a_resync_clears: assert property (@(posedge clk) disable iff (!rstn)
        resync_cmd && !sync_lost |=> !out_of_sync_flag) // RL12
        else $error("resync did not clear the status");

    // Status read shows the live ready level and zero low bits
    a_status_read: assert property (@(posedge clk) disable iff (!rstn)
        reg_rd && reg_addr == cfg_regs_pkg::FIRST_STATUS_ADDR
        |=> reg_rdata[6] == $past(optical_link_ready)
            && reg_rdata[5:0] == 6'h00) // RL10
        else $error("status read wrong");

    // Extended register reads zero above bit 1
    a_ext_read_zero: assert property (@(posedge clk) disable iff (!rstn)
        reg_rd && reg_addr == cfg_regs_pkg::EXTENDED_CONFIGURATION_ADDR
        |=> reg_rdata[7:2] == 6'h00) // RL11
        else $error("unassigned extended bits not zero");

    // No FIFO strobe outside link test
    a_fifo_gated: assert property (@(posedge clk) disable iff (!rstn)
        (reg_wr || reg_rd) && !link_test |=> !fifo_wr && !fifo_rd) // RL14
        else $error("FIFO strobe outside link test");

    // Masked events never appear when the mask stood for the whole count
    a_cal_masked: assert property (@(posedge clk) disable iff (!rstn)
        ext_cfg_r[cfg_regs_pkg::CAL_EVENT_MASK_BIT] [*2]
        |-> !cal_event) // RL7
        else $error("masked calibration event issued");

    // With default latency and no mask, the event lands 128 cycles on
    a_cal_latency: assert property (@(posedge clk) disable iff (!rstn)
        cal_cmd && !cal_busy && latency_r == LAT_W'(128)
        && !ext_cfg_r[cfg_regs_pkg::CAL_EVENT_MASK_BIT]
        && !(reg_wr && reg_addr == cfg_regs_pkg::EXTENDED_CONFIGURATION_ADDR)
        ##1 !ext_cfg_r[cfg_regs_pkg::CAL_EVENT_MASK_BIT] [*8]
        |-> ##121 (cal_event ||
            $past(ext_cfg_r[cfg_regs_pkg::CAL_EVENT_MASK_BIT]))) // RL13
        else $error("calibration event not at the latency");

endmodule : front_end_config_status_regs

// file: front_end_config_status_regs_bench.sv
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin total_checks++; \
    if ((got) !== (exp)) begin n_mismatch++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end

module front_end_config_status_regs_bench;
    // Short aliases for the offsets
    localparam logic [7:0] A_MAIN = cfg_regs_pkg::MAIN_CONFIGURATION_ADDR;
    localparam logic [7:0] A_EXT = cfg_regs_pkg::EXTENDED_CONFIGURATION_ADDR;
    localparam logic [7:0] A_LAT = cfg_regs_pkg::LATENCY_ADDR;
    localparam logic [7:0] A_SEL = cfg_regs_pkg::FIFO_SELECT_ADDR;
    localparam logic [7:0] A_HI = cfg_regs_pkg::FIFO_DATA_HI_ADDR;
    localparam logic [7:0] A_LO = cfg_regs_pkg::FIFO_DATA_LO_ADDR;
    localparam logic [7:0] A_STAT = cfg_regs_pkg::FIRST_STATUS_ADDR;

    logic clk, rstn, reg_wr, reg_rd, resync_cmd, cal_cmd, sync_lost;
    logic optical_link_ready, mode, inh, txd, ltest, ch_d, ch_c, ch_b, ch_a;
    logic dll_disable, out_of_sync_flag, cal_event, fifo_wr, fifo_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [5:0] fifo_select;
    logic [11:0] fifo_wdata, fifo_rdata;
    logic [7:0] pat [0:1] = '{8'hD5, 8'h2A}; // Each bit both ways
    int n_mismatch = 0, total_checks = 0, n_fwr = 0, n_cal = 0, n;
    int n_frd = 0;

    front_end_config_status_regs #(.LAT_W(8)) dut (.clk(clk), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .resync_cmd(resync_cmd), .cal_cmd(cal_cmd), .sync_lost(sync_lost),
        .optical_link_ready(optical_link_ready),
        .operating_mode_select(mode), .trigger_inhibit_select(inh),
        .link_transmit_disable(txd), .link_test_select(ltest),
        .input_channel_d_enable(ch_d), .input_channel_c_enable(ch_c),
        .input_channel_b_enable(ch_b), .input_channel_a_enable(ch_a),
        .dll_disable(dll_disable), .out_of_sync_flag(out_of_sync_flag),
        .cal_event(cal_event), .fifo_select(fifo_select), .fifo_wr(fifo_wr),
        .fifo_wdata(fifo_wdata), .fifo_rd(fifo_rd), .fifo_rdata(fifo_rdata));

    fifo_partner far_fifo (.clk(clk), .rstn(rstn), .fifo_select(fifo_select),
        .fifo_wr(fifo_wr), .fifo_wdata(fifo_wdata), .fifo_rd(fifo_rd),
        .fifo_rdata(fifo_rdata));

    // Clock at 40 MHz
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Strobe counters, so missing or extra pulses show up
    always @(posedge clk) begin
        if (fifo_wr === 1'b1) n_fwr++;
        if (fifo_rd === 1'b1) n_frd++;
        if (cal_event === 1'b1) n_cal++;
    end

    // Verdict and end of run
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    // One write pulse; entered and left at a falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge clk) reg_wr = 1'b0;
        @(negedge clk);
    endtask : wr

    // One read pulse, then compare the returned byte
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e,
                          input string nm);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk) reg_rd = 1'b0;
        @(negedge clk) d = reg_rdata;
        `CHK(nm, e, d)
    endtask : chk_rd

    // Cycles from an accepted command to the event; bounded wait
    task automatic cal_run(output int c);
        cal_cmd = 1'b1;
        @(negedge clk) cal_cmd = 1'b0;
        c = 0;
        while (cal_event !== 1'b1 && c < 200) begin
            @(negedge clk) c++;
        end
        if (c >= 200) begin
            n_mismatch++;
            close_out();
        end
        @(negedge clk);
        `CHK("event width", 1'b0, cal_event)
    endtask : cal_run

    initial begin
        {rstn, reg_wr, reg_rd, resync_cmd, cal_cmd, sync_lost} = 6'h00;
        {reg_addr, reg_wdata, optical_link_ready} = 17'h00000;
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        // Values after reset
        chk_rd(A_MAIN, 8'h00, "main");
        chk_rd(A_EXT, 8'h00, "ext");
        chk_rd(A_LAT, 8'h80, "latency");
        chk_rd(A_STAT, 8'h00, "status");
        `CHK("select", 6'h00, fifo_select)
        $display("test reset values done");
        // Main configuration bits both ways
        for (int i = 0; i < 2; i++) begin
            wr(A_MAIN, pat[i]);
            `CHK("mode", pat[i][7], mode)
            `CHK("inhibit", pat[i][6], inh)
            `CHK("tx disable", pat[i][5], txd)
            `CHK("link test", pat[i][4], ltest)
            `CHK("chan", pat[i][3:0], {ch_d, ch_c, ch_b, ch_a})
            chk_rd(A_MAIN, pat[i], "main back");
        end
        $display("test main config done");
        // Extended bits and read-only status
        wr(A_EXT, 8'hFF);
        `CHK("dll", 1'b1, dll_disable)
        chk_rd(A_EXT, 8'h03, "ext back");
        wr(A_STAT, 8'hFF);
        chk_rd(A_STAT, 8'h00, "status ro");
        wr(A_EXT, 8'h00);
        `CHK("dll", 1'b0, dll_disable)
        chk_rd(8'h0A, 8'h00, "unmapped");
        $display("test extended done");
        // Live ready level and sticky flag
        optical_link_ready = 1'b1;
        chk_rd(A_STAT, 8'h40, "ready");
        sync_lost = 1'b1;
        @(negedge clk) sync_lost = 1'b0;
        repeat (10) @(negedge clk);
        `CHK("oos", 1'b1, out_of_sync_flag)
        chk_rd(A_STAT, 8'hC0, "status both");
        optical_link_ready = 1'b0;
        chk_rd(A_STAT, 8'h80, "ready low");
        resync_cmd = 1'b1;
        @(negedge clk) resync_cmd = 1'b0;
        @(negedge clk);
        `CHK("oos clr", 1'b0, out_of_sync_flag)
        chk_rd(A_STAT, 8'h00, "status clr");
        $display("test status done");
        // Calibration latency, default then programmed, then masked
        cal_run(n);
        `CHK("lat default", 128, n)
        wr(A_LAT, 8'h05);
        cal_run(n);
        `CHK("lat 5", 5, n)
        wr(A_LAT, 8'h01);
        cal_run(n);
        `CHK("lat 1", 1, n)
        wr(A_EXT, 8'h02);
        n = n_cal;
        cal_cmd = 1'b1;
        @(negedge clk) cal_cmd = 1'b0;
        repeat (20) @(negedge clk);
        `CHK("masked", n, n_cal)
        wr(A_EXT, 8'h00);
        $display("test calibration done");
        // FIFO data ignored in normal mode, reached in link test
        wr(A_HI, 8'h0A);
        wr(A_LO, 8'h5C);
        `CHK("no push", 0, n_fwr)
        chk_rd(A_LO, 8'h00, "fifo normal");
        `CHK("no pop", 0, n_frd)
        wr(A_MAIN, 8'h10);
        wr(A_SEL, 8'h01);
        `CHK("select", 6'h01, fifo_select)
        wr(A_HI, 8'h0A);
        wr(A_LO, 8'h5C);
        `CHK("push", 1, n_fwr)
        `CHK("push word", 12'hA5C, fifo_wdata)
        chk_rd(A_LO, 8'h5C, "fifo lo");
        `CHK("pop", 1, n_frd)
        chk_rd(A_HI, 8'h0A, "fifo hi");
        $display("test fifo done");
        // Reset in mid-run clears the mode bits
        wr(A_MAIN, 8'hFF);
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
        `CHK("modes", 4'h0, {mode, inh, txd, ltest})
        chk_rd(A_MAIN, 8'h00, "main rst");
        $display("test second reset done");
        close_out();
    end
endmodule : front_end_config_status_regs_bench
